// *** testbench/pwm_load_model.sv ***
// Load model standing on the channel pins.
module pwm_load_model
   import timer_cmp_pkg::*;
(
   // Clock and control
   input  wire logic       clk,
   input  wire logic       clr,
   // Pins
   input  wire logic [3:0] mainOut,
   input  wire logic [2:0] compOut,
   // Counts
   output      int         highCnt,
   output      int         bothCnt
);
   timeunit 1ns;
   timeprecision 1ns;

   // One load only, on the channel 0 main and complementary pins; channel 4 never reaches a pin.
   always @(posedge clk)
   begin
      if (clr)
      begin
         highCnt <= 0;
         bothCnt <= 0;
      end
      else
      begin
         highCnt <= highCnt + int'(mainOut[0] === 1'b1);
         bothCnt <= bothCnt + int'((mainOut[0] & compOut[0]) === 1'b1);
      end
   end
endmodule : pwm_load_model

// *** testbench/tb.sv ***
// Self-checking bench for the compare/PWM output stage.
`include "timer_cmp_cfg.svh"
module tb
   import timer_cmp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   reg_req_s    regReq = '0;
   logic [31:0] rdata;
   logic        trigIn = 1'b0;
   logic        etrIn = 1'b0;
   logic [3:0]  mainOut;
   logic [2:0]  compOut;
   logic [4:0]  chIrq;
   logic [4:0]  chDmaReq;
   logic        clr = 1'b1;
   logic        reWas = 1'b0;
   int          highCnt;
   int          bothCnt;
   int          dmaCnt;
   int          hc;
   int          bc;
   int          dc;
   int          num_errors = 0;
   int          checked = 0;
   integer      seed = 32'hf116a166;
   logic [31:0] v;
   logic [31:0] expQ[$];
   logic [31:0] mskQ[$];
   localparam logic [19:0] MODES [10] = '{20'h5, 20'h4, 20'h6, 20'h7, 20'h5C,
      20'h4D, 20'h5D, 20'h40007, 20'h50007, 20'h5};
   localparam logic [31:0] CFGS [10] = '{10{32'h10}};
   localparam logic [9:0]  EXPS = 10'b0101011001;

   always #20 clk = ~clk;

   timer_compare_pwm_output_stage uut (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .regReq   (regReq),
      .rdata    (rdata),
      .trigIn   (trigIn),
      .etrIn    (etrIn),
      .mainOut  (mainOut),
      .compOut  (compOut),
      .chIrq    (chIrq),
      .chDmaReq (chDmaReq)
   );

   pwm_load_model load (
      .clk     (clk),
      .clr     (clr),
      .mainOut (mainOut),
      .compOut (compOut),
      .highCnt (highCnt),
      .bothCnt (bothCnt)
   );

   // ------
   // Tasks
   // ------
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e)
      begin
         num_errors++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask : cmp

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regReq <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge clk);
   endtask : wr

   // Strobes stay up between back-to-back calls; idle drops them.
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      regReq <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
      expQ.push_back(e & m);
      mskQ.push_back(m);
      @(posedge clk);
   endtask : rd

   task automatic idle(input int n);
      regReq <= '0;
      repeat (n) @(posedge clk);
   endtask : idle

   task automatic meas(input int n);
      clr <= 1'b0;
      idle(n);
      #1;
      hc = highCnt;
      bc = bothCnt;
      dc = dmaCnt;
      clr <= 1'b1;
      @(posedge clk);
   endtask : meas

   task automatic trig();
      trigIn <= 1'b1;
      idle(2);
      trigIn <= 1'b0;
   endtask : trig

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test

   always @(posedge clk)
   begin
      dmaCnt <= clr ? 0 : dmaCnt + int'(chDmaReq[0] === 1'b1);
      reWas <= regReq.re;
      if (reWas)
         cmp("rdata", expQ.pop_front(), rdata & mskQ.pop_front());
   end

   initial
   begin
      #(40 * 6000);
      num_errors++;
      finish_test();
   end

   // ------
   // Scenarios
   // ------
   initial
   begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      v = $random(seed) & 32'h0000FFF0;
      rd(`OFS_RELOAD, `RST_RELOAD, '1);
      rd(`OFS_CV4, `RST_CV, '1);
      rd(8'h3C, 32'h0, '1);
      wr(`OFS_RELOAD, v);
      rd(`OFS_RELOAD, v, '1);
      wr(`OFS_COUNT, 32'hABCD);
      rd(`OFS_COUNT, 32'h0, '1);
      wr(`OFS_RELOAD, 32'h9);
      wr(`OFS_CV0, 32'h14);
      wr(`OFS_CTRL, 32'h1);
      for (int i = 0; i < 10; i++)
      begin
         wr(`OFS_MODE, {12'h0, MODES[i]});
         wr(`OFS_ENABLE, (i == 7 || i == 8) ? 32'h400 : 32'h0);
         wr(`OFS_CHCFG, (i == 9) ? 32'h14 : CFGS[i]);
         idle(6);
         cmp("main0", EXPS[i], mainOut[0]);
      end
      wr(`OFS_RELOAD, 32'h3);
      wr(`OFS_CV0, 32'h2);
      wr(`OFS_ENABLE, 32'h21);
      wr(`OFS_CHCFG, 32'h10);
      wr(`OFS_MODE, 32'h3);
      idle(8);
      cmp("main0", 32'h0, mainOut[0]);
      wr(`OFS_MODE, 32'h0);
      idle(8);
      cmp("main0", 32'h0, mainOut[0]);
      wr(`OFS_MODE, 32'h1);
      meas(40);
      cmp("main0", 32'h1, mainOut[0]);
      cmp("irq0", 32'h1, chIrq[0]);
      cmp("dma", 32'd10, dc);
      rd(`OFS_FLAG, 32'h1, 32'h1);
      wr(`OFS_MODE, 32'h2);
      meas(40);
      cmp("toggle", 32'd20, hc);
      wr(`OFS_CV0, 32'h1);
      wr(`OFS_MODE, 32'h6);
      wr(`OFS_CHCFG, 32'h31);
      for (int j = 0; j < 4; j++)
      begin
         wr(`OFS_CTRL, (j == 1) ? 32'h3 : (j == 3) ? 32'h5 : 32'h1);
         wr(`OFS_RELOAD, (j >= 2) ? 32'h4 : 32'h3);
         idle(10);
         meas(40);
         cmp("duty", (j == 0 || j == 3) ? 30 : (j == 1) ? 20 : 32, hc);
         cmp("both", 32'h0, bc);
      end
      wr(`OFS_CTRL, 32'h1);
      wr(`OFS_RELOAD, 32'h3);
      wr(`OFS_CV0, 32'h2);
      wr(`OFS_CHCFG, 32'h12);
      wr(`OFS_MODE, 32'h1);
      idle(8);
      etrIn <= 1'b1;
      idle(14);
      cmp("main0", 32'h0, mainOut[0]);
      etrIn <= 1'b0;
      idle(14);
      cmp("main0", 32'h1, mainOut[0]);
      // Slave pulse setup: compare 0, reload sets length, edge counting.
      wr(`OFS_CTRL, 32'h11);
      wr(`OFS_CV0, 32'h0);
      wr(`OFS_RELOAD, 32'h14);
      wr(`OFS_CHCFG, 32'h10);
      wr(`OFS_MODE, 32'hC);
      idle(30);
      trig();
      idle(8);
      cmp("pulse", 32'h1, mainOut[0]);
      idle(30);
      cmp("pulse", 32'h0, mainOut[0]);
      trig();
      idle(13);
      trig();
      idle(18);
      cmp("pulse", 32'h1, mainOut[0]);
      idle(35);
      cmp("pulse", 32'h0, mainOut[0]);
      finish_test();
   end
endmodule : tb

// *** verilog/oc_channel_stage.sv ***
// One compare channel: match detection and the prepare signal it builds.
`include "timer_cmp_cfg.svh"

module oc_channel_stage
   import timer_cmp_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // Configuration
   input  wire logic [3:0] mode,
   input  wire logic       clrEn,
   input  wire logic       spm,
   // Counter view
   input  wire cnt_t       cnt,
   input  wire cnt_t       cv,
   input  wire logic       dirDown,
   input  wire logic       run,
   input  wire logic       upd,
   input  wire logic       pulseRun,
   input  wire logic       etr,
   // Results
   output      logic       prep,
   output      logic       match
);

   ch_state_s s_r;
   ch_state_s s_nxt;
   logic      pwmLvl;

   assign match = run && (cnt == cv);
   assign prep  = s_r.prep;

   // ----------------------------------------------------------------------------
   // Prepare signal
   // ----------------------------------------------------------------------------
   always_comb
   begin
      s_nxt  = s_r;
      pwmLvl = dirDown ? (cnt > cv) : (cnt >= cv);
      if (upd)
         s_nxt.clrHold = 1'b0;
      if (clrEn && etr)
         s_nxt.clrHold = 1'b1;
      case (mode)
         `MODE_HOLD:     s_nxt.prep = s_r.prep;
         `MODE_SET:      if (match) s_nxt.prep = 1'b1;
         `MODE_TOGGLE:   if (match) s_nxt.prep = ~s_r.prep;
         `MODE_CLEAR:    if (match) s_nxt.prep = 1'b0;
         `MODE_FORCE_LO: s_nxt.prep = 1'b0;
         `MODE_FORCE_HI: s_nxt.prep = 1'b1;
         default:
         begin
            // In pulse mode the combined modes take their level from the pulse, not from a compare.
            if (spm && (mode == `MODE_COMB0 || mode == `MODE_COMB1))
               s_nxt.prep = pulseRun ^ mode[0];
            else
               s_nxt.prep = pwmLvl ^ mode[0];
         end
      endcase
      if (s_nxt.clrHold)
         s_nxt.prep = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_set_on_match;
      (mode == `MODE_SET) && match && !(clrEn && etr) && (!s_r.clrHold || upd) |=> prep;
   endproperty
   a_set_on_match: assert property (p_set_on_match) else $error("set mode missed");

   property p_toggle;
      (mode == `MODE_TOGGLE) && match && !(clrEn && etr) && (!s_r.clrHold || upd)
         |=> prep != $past(prep);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle mode missed");

   property p_force_lo;
      (mode == `MODE_FORCE_LO) [*2] |-> !prep;
   endproperty
   a_force_lo: assert property (p_force_lo) else $error("force low failed");

   property p_clear_hold;
      (clrEn && etr) ##1 (!upd) |=> !prep;
   endproperty
   a_clear_hold: assert property (p_clear_hold) else $error("trigger clear lost");

endmodule : oc_channel_stage

// *** verilog/timer_cmp_cfg.svh ***
// Offsets, field positions, codes and reset values of the compare/PWM stage.
`ifndef TIMER_CMP_CFG_SVH
`define TIMER_CMP_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_CTRL       8'h00
`define OFS_RELOAD     8'h04
`define OFS_MODE       8'h08
`define OFS_CHCFG      8'h0C
`define OFS_ENABLE     8'h10
`define OFS_FLAG       8'h14
`define OFS_COUNT      8'h18
`define OFS_CV0        8'h20
`define OFS_CV4        8'h30

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTRL_CEN       0
`define CTRL_DIR       1
`define CTRL_CAM_LO    2
`define CTRL_SPM       4
`define CF_WIDTH       6
`define CF_SHADOW      0
`define CF_CLR         1
`define CF_MPOL        2
`define CF_CPOL        3
`define CF_MEN         4
`define CF_CEN         5
`define EN_IRQ_LO      0
`define EN_DMA_LO      5
`define EN_3PH_LO      10
`define FLAG_PREP4     8

// ----------------------------------------------------------------------------
// Compare mode codes
// ----------------------------------------------------------------------------
`define MODE_HOLD      4'h0
`define MODE_SET       4'h1
`define MODE_TOGGLE    4'h2
`define MODE_CLEAR     4'h3
`define MODE_FORCE_LO  4'h4
`define MODE_FORCE_HI  4'h5
`define MODE_PWM0      4'h6
`define MODE_PWM1      4'h7
`define MODE_COMB0     4'hC
`define MODE_COMB1     4'hD
`define MODE_ASYM0     4'hE
`define MODE_ASYM1     4'hF

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_RELOAD     16'hFFFF
`define RST_CV         16'h0000

`endif

// *** verilog/timer_cmp_pkg.sv ***
// Types shared by the compare/PWM stage modules.
package timer_cmp_pkg;

   typedef logic [15:0] cnt_t;

   typedef enum logic {DIR_UP, DIR_DOWN} cnt_dir_e;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        we;
      logic        re;
   } reg_req_s;

   typedef struct packed {
      logic prep;
      logic clrHold;
   } ch_state_s;

   typedef struct packed {
      cnt_t            cnt;
      cnt_dir_e        dir;
      logic            pulseRun;
      logic [1:0]      trigSync;
      logic            trigPrev;
      logic [1:0]      etrSync;
      logic            count_enable_bit;
      logic            dirCfg;
      logic [1:0]      center_align_mode_field;
      logic            spm;
      cnt_t            reload;
      logic [4:0][3:0] mode;
      logic [29:0]     chcfg;
      logic [4:0]      irqEn;
      logic [4:0]      dmaEn;
      logic [2:0]      sel3;
      logic [4:0]      flag;
      cnt_t [4:0]      cvSh;
      cnt_t [4:0]      cvAct;
      logic [31:0]     rdata;
      logic [3:0]      mainOut;
      logic [2:0]      compOut;
      logic [4:0]      irq;
      logic [4:0]      dma;
      logic            upd;
   } top_state_s;

endpackage : timer_cmp_pkg

// *** verilog/timer_compare_pwm_output_stage.sv ***
// Output compare and PWM stage: counter, registers, five channels, output pins.
//
// Our own choices: strobed register access and the register offsets.
`include "timer_cmp_cfg.svh"

module timer_compare_pwm_output_stage
   import timer_cmp_pkg::*;
#(
   parameter int NUM_CH = 5
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Register port
   input  wire reg_req_s    regReq,
   output      logic [31:0] rdata,
   // Trigger pins
   input  wire logic        trigIn,
   input  wire logic        etrIn,
   // Channel pins
   output      logic [3:0]  mainOut,
   output      logic [2:0]  compOut,
   // Requests
   output      logic [4:0]  chIrq,
   output      logic [4:0]  chDmaReq
);

   top_state_s  r;
   top_state_s  n;
   logic        run;
   logic        trigEdge;
   logic        updEv;
   logic        etr;
   logic [4:0]  prepV;
   logic [4:0]  matchV;
   logic [4:0]  comb;
   cnt_t [4:0]  cvEff;
   logic [2:0]  cvIdx;

   assign run      = r.count_enable_bit && (!r.spm || r.pulseRun);
   assign trigEdge = r.trigSync[1] && !r.trigPrev;
   assign etr      = r.etrSync[1];
   assign cvIdx    = 3'((regReq.addr - `OFS_CV0) >> 2);

   // ----------------------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++)
      begin : g_ch
         localparam int PARTNER = (gi < 4) ? (gi ^ 1) : gi;
         // Asymmetric modes on channels 0 to 3 follow the partner's compare while counting down.
         assign cvEff[gi] = (r.mode[gi][3:1] == 3'b111 && r.dir == DIR_DOWN)
                            ? r.cvAct[PARTNER] : r.cvAct[gi];
         oc_channel_stage u_ch (
            .clk      (clk),
            .sys_rst  (sys_rst),
            .mode     (r.mode[gi]),
            .clrEn    (r.chcfg[`CF_WIDTH*gi + `CF_CLR]),
            .spm      (r.spm),
            .cnt      (r.cnt),
            .cv       (cvEff[gi]),
            .dirDown  (r.dir == DIR_DOWN),
            .run      (run),
            .upd      (r.upd),
            .pulseRun (r.pulseRun),
            .etr      (etr),
            .prep     (prepV[gi]),
            .match    (matchV[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------------
   always_comb
   begin
      n          = r;
      updEv      = 1'b0;
      n.trigSync = {r.trigSync[0], trigIn};
      n.trigPrev = r.trigSync[1];
      n.etrSync  = {r.etrSync[0], etrIn};

      // Counter; a trigger in pulse mode restarts it, which also extends a pulse.
      if (r.spm && trigEdge)
      begin
         n.pulseRun = 1'b1;
         n.cnt      = r.dirCfg ? r.reload : 16'h0000;
         n.dir      = r.dirCfg ? DIR_DOWN : DIR_UP;
      end
      else if (run)
      begin
         if (r.center_align_mode_field == 2'b00)
         begin
            n.dir = r.dirCfg ? DIR_DOWN : DIR_UP;
            if (!r.dirCfg)
            begin
               updEv = (r.cnt >= r.reload);
               n.cnt = updEv ? 16'h0000 : r.cnt + 16'h0001;
            end
            else
            begin
               updEv = (r.cnt == 16'h0000);
               n.cnt = updEv ? r.reload : r.cnt - 16'h0001;
            end
         end
         else if (r.dir == DIR_UP)
         begin
            // Center alignment walks up then down, for a period of twice the reload value.
            updEv = (r.cnt >= r.reload);
            n.dir = updEv ? DIR_DOWN : DIR_UP;
            n.cnt = updEv ? r.cnt - 16'h0001 : r.cnt + 16'h0001;
         end
         else
         begin
            updEv = (r.cnt == 16'h0000);
            n.dir = updEv ? DIR_UP : DIR_DOWN;
            n.cnt = updEv ? 16'h0001 : r.cnt - 16'h0001;
         end
         if (updEv && r.spm)
            n.pulseRun = 1'b0;
      end
      n.upd = updEv;

      // Register writes.
      if (regReq.we)
      begin
         if (regReq.addr == `OFS_CTRL)
         begin
            n.count_enable_bit    = regReq.wdata[`CTRL_CEN];
            n.dirCfg = regReq.wdata[`CTRL_DIR];
            n.center_align_mode_field    = regReq.wdata[`CTRL_CAM_LO +: 2];
            n.spm    = regReq.wdata[`CTRL_SPM];
         end
         else if (regReq.addr == `OFS_RELOAD)
            n.reload = regReq.wdata[15:0];
         else if (regReq.addr == `OFS_MODE)
            n.mode = regReq.wdata[19:0];
         else if (regReq.addr == `OFS_CHCFG)
            n.chcfg = regReq.wdata[29:0];
         else if (regReq.addr == `OFS_ENABLE)
         begin
            n.irqEn = regReq.wdata[`EN_IRQ_LO +: 5];
            n.dmaEn = regReq.wdata[`EN_DMA_LO +: 5];
            n.sel3  = regReq.wdata[`EN_3PH_LO +: 3];
         end
         else if (regReq.addr == `OFS_FLAG)
            n.flag = r.flag & ~regReq.wdata[4:0];
         else if (regReq.addr >= `OFS_CV0 && regReq.addr <= `OFS_CV4
                  && regReq.addr[1:0] == 2'b00)
            n.cvSh[cvIdx] = regReq.wdata[15:0];
      end

      // With shadowing the active compare only moves at a wrap or a center-aligned turn, so a shadowed write never splits an edge-aligned period.
      for (int i = 0; i < NUM_CH; i++)
      begin
         // Without shadowing a new compare value applies at once.
         if (!r.chcfg[`CF_WIDTH*i + `CF_SHADOW] || updEv)
            n.cvAct[i] = n.cvSh[i];
      end

      // Match flags win over a clear in the same cycle.
      n.flag = n.flag | matchV;
      n.irq  = n.flag & r.irqEn;
      n.dma  = matchV & r.dmaEn;

      // Combined prepare signals.
      for (int i = 0; i < NUM_CH; i++)
      begin
         if (i < 4 && !r.spm && r.mode[i] == `MODE_COMB0)
            comb[i] = prepV[i] | prepV[i ^ 1];
         else if (i < 4 && !r.spm && r.mode[i] == `MODE_COMB1)
            comb[i] = prepV[i] & prepV[i ^ 1];
         else
            comb[i] = prepV[i];
         if (i < 3 && r.sel3[i])
            comb[i] = comb[i] & prepV[4];
      end

      // Pins; channel 4 stays internal and has no pin at all.
      for (int i = 0; i < 4; i++)
      begin
         n.mainOut[i] = r.chcfg[`CF_WIDTH*i + `CF_MEN]
                        & (comb[i] ^ r.chcfg[`CF_WIDTH*i + `CF_MPOL]);
      end
      for (int i = 0; i < 3; i++)
      begin
         n.compOut[i] = r.chcfg[`CF_WIDTH*i + `CF_CEN]
                        & (~comb[i] ^ r.chcfg[`CF_WIDTH*i + `CF_CPOL]);
      end

      // Read data, valid in the cycle after the strobe only.
      n.rdata = 32'h0000_0000;
      if (regReq.re)
      begin
         if (regReq.addr == `OFS_CTRL)
            n.rdata = {27'h0, r.spm, r.center_align_mode_field, r.dirCfg, r.count_enable_bit};
         else if (regReq.addr == `OFS_RELOAD)
            n.rdata = {16'h0000, r.reload};
         else if (regReq.addr == `OFS_MODE)
            n.rdata = {12'h000, r.mode};
         else if (regReq.addr == `OFS_CHCFG)
            n.rdata = {2'b00, r.chcfg};
         else if (regReq.addr == `OFS_ENABLE)
            n.rdata = {19'h0, r.sel3, r.dmaEn, r.irqEn};
         else if (regReq.addr == `OFS_FLAG)
            n.rdata = {23'h0, prepV[4], 3'b000, r.flag};
         else if (regReq.addr == `OFS_COUNT)
            n.rdata = {14'h0, r.pulseRun, r.dir == DIR_DOWN, r.cnt};
         else if (regReq.addr >= `OFS_CV0 && regReq.addr <= `OFS_CV4
                  && regReq.addr[1:0] == 2'b00)
            n.rdata = {16'h0000, r.cvSh[cvIdx]};
      end
   end

   // ----------------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         r        <= '0;
         r.reload <= `RST_RELOAD;
         r.cvSh   <= {NUM_CH{`RST_CV}};
         r.cvAct  <= {NUM_CH{`RST_CV}};
      end
      else
         r <= n;
   end

   assign rdata    = r.rdata;
   assign mainOut  = r.mainOut;
   assign compOut  = r.compOut;
   assign chIrq    = r.irq;
   assign chDmaReq = r.dma;

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_flag_set;
      matchV[0] |=> r.flag[0] ##1 (r.flag[0] || $past(regReq.we));
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("match flag not set");

   property p_irq;
      matchV[2] && r.irqEn[2] && !(regReq.we && regReq.addr == `OFS_ENABLE) |=> chIrq[2];
   endproperty
   a_irq: assert property (p_irq) else $error("channel interrupt missing");

   property p_dma;
      (matchV[1] && r.dmaEn[1] |=> chDmaReq[1]) and (!matchV[1] |=> !chDmaReq[1]);
   endproperty
   a_dma: assert property (p_dma) else $error("dma request wrong");

   property p_pwm0_over;
      r.mode[0] == `MODE_PWM0 && r.center_align_mode_field == 2'b00 && !r.dirCfg && !r.spm
         && r.cvAct[0] > r.reload && r.cnt <= r.reload |=> !prepV[0];
   endproperty
   a_pwm0_over: assert property (p_pwm0_over) else $error("pwm0 not inactive");

   property p_comb_or;
      r.mode[0] == `MODE_COMB0 && !r.spm && !r.sel3[0] && r.chcfg[`CF_MEN]
         && !r.chcfg[`CF_MPOL] |=> mainOut[0] == $past(prepV[0] | prepV[1]);
   endproperty
   a_comb_or: assert property (p_comb_or) else $error("combined or wrong");

   property p_three_phase;
      r.sel3[1] && !prepV[4] && r.chcfg[`CF_WIDTH + `CF_MEN] |=> !mainOut[1]
         || $past(r.chcfg[`CF_WIDTH + `CF_MPOL]);
   endproperty
   a_three_phase: assert property (p_three_phase) else $error("three phase leak");

   property p_no_overlap;
      !r.chcfg[`CF_MPOL] && !r.chcfg[`CF_CPOL] |=> !(mainOut[0] && compOut[0]);
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("outputs co-active");

   property p_pulse_start;
      r.spm && trigEdge |=> r.pulseRun ##1 (r.pulseRun || r.upd || !r.count_enable_bit);
   endproperty
   a_pulse_start: assert property (p_pulse_start) else $error("pulse not started");

   property p_shadow;
      r.chcfg[`CF_SHADOW] && !updEv && !$past(r.chcfg[`CF_SHADOW] == 1'b0)
         |=> r.cvAct[0] == $past(r.cvAct[0]);
   endproperty
   a_shadow: assert property (p_shadow) else $error("shadow bypassed");

   property p_pwm1_over;
      r.mode[0] == `MODE_PWM1 && r.center_align_mode_field == 2'b00 && !r.dirCfg && !r.spm && !r.chcfg[`CF_CLR]
         && r.cvAct[0] > r.reload && r.cnt <= r.reload |=> prepV[0];
   endproperty
   a_pwm1_over: assert property (p_pwm1_over) else $error("pwm1 not active");

   property p_comb_and;
      r.mode[0] == `MODE_COMB1 && !r.spm && !r.sel3[0] && r.chcfg[`CF_MEN]
         && !r.chcfg[`CF_MPOL] |=> mainOut[0] == $past(prepV[0] & prepV[1]);
   endproperty
   a_comb_and: assert property (p_comb_and) else $error("combined and wrong");

   property p_asym;
      r.mode[0] == `MODE_ASYM0 && r.dir == DIR_DOWN |-> cvEff[0] == r.cvAct[1];
   endproperty
   a_asym: assert property (p_asym) else $error("asymmetric compare wrong");

   property p_pulse_extend;
      r.spm && r.pulseRun && trigEdge && !r.dirCfg |=> r.pulseRun && r.cnt == 16'h0000;
   endproperty
   a_pulse_extend: assert property (p_pulse_extend) else $error("retrigger lost");

   c_match_irq: cover property (matchV[0] && r.irqEn[0] ##1 chIrq[0]);
   c_retrigger: cover property (r.pulseRun && trigEdge);
   c_comb_and:  cover property (r.mode[2] == `MODE_COMB1 && prepV[2] && prepV[3]);
   c_center:    cover property (r.center_align_mode_field != 2'b00 && updEv && r.dir == DIR_DOWN);

endmodule : timer_compare_pwm_output_stage
